// *** src/scb_pkg.sv ***
// package: register map, field layout and types for the system config block
package scb_pkg;

  // register byte offsets inside the 64 Kbyte special-register window
  localparam logic [15:0] SCB_OFS_CONFIG = 16'h0000;
  localparam logic [15:0] SCB_OFS_CLKDIV = 16'h3000;
  localparam logic [15:0] SCB_OFS_STATUS = 16'hfffc;

  // system bus address width and window base field position
  localparam int          SCB_AW         = 26;
  localparam int          SCB_WIN_LSB    = 16;
  localparam int          SCB_WIN_W      = 10;

  // system_configuration fields
  localparam int          SCB_CFG_STALL  = 0;
  localparam int          SCB_CFG_CE     = 1;
  localparam int          SCB_CFG_WBE    = 2;
  localparam int          SCB_CFG_CM_LSB = 4;
  localparam int          SCB_CFG_SR_LSB = 6;
  localparam int          SCB_CFG_SB_LSB = 16;
  localparam int          SCB_CFG_ID_LSB = 26;
  localparam int          SCB_CFG_SDRAM  = 31;
  localparam logic [31:0] SCB_CFG_RESET  = 32'h37ffff91;
  localparam logic [31:0] SCB_CFG_WMASK  = 32'h83fffff7;
  localparam logic [1:0]  SCB_CM_NOCACHE = 2'h2;

  // clock_divide_control fields
  localparam int          SCB_CLK_WAIT   = 16;
  localparam int          SCB_CLK_MUX    = 17;
  localparam int          SCB_CLK_APH    = 18;
  localparam int          SCB_CLK_TEST   = 31;
  localparam logic [31:0] SCB_CLK_RESET  = 32'h00000000;
  localparam logic [31:0] SCB_CLK_WMASK  = 32'h800fffff;

  // status register bits
  localparam int          SCB_ST_GRANT   = 0;
  localparam int          SCB_ST_REQ     = 1;
  localparam int          SCB_ST_DRAIN   = 2;

  // handover states, gray along own -> drain -> granted -> release
  typedef enum logic [1:0] {
    SCB_OWN     = 2'h0,
    SCB_DRAIN   = 2'h1,
    SCB_GRANTED = 2'h3,
    SCB_RELEASE = 2'h2
  } scb_state_t;

  // external memory interface driven by the memory controller
  typedef struct packed {
    logic [21:0] addr;
    logic [31:0] data;
    logic [15:0] ctrl;
  } scb_mem_t;

  // decoded configuration handed to the cache, buffer and bus logic
  typedef struct packed {
    logic [SCB_WIN_W-1:0] special_base;
    logic [9:0]           sram_base;
    logic [1:0]           cache_mode;
    logic                 cache_enable;
    logic                 write_buffer_enable;
    logic                 write_through;
    logic                 stall_enable;
    logic                 sync_dram_mode;
    logic                 bank5_wait_enable;
    logic                 bank5_mux_enable;
    logic [1:0]           mux_address_phase_time;
    logic                 factory_test;
  } scb_cfg_t;

endpackage : scb_pkg

// *** src/scb_clkdiv.sv ***
// one-hot system clock divider producing a low-duty clock tick
`timescale 1ns/1ps
module scb_clkdiv
  import scb_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic [15:0] div_onehot,
  output logic             sclk_tick
);

  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic        tick_reg;
  logic        tick_next;
  logic [15:0] last;

  ////////////////////////////////////////////////////////////////////////////
  // a zero field never waits, so the tick stays high: undivided clock
  always_comb begin
    last      = div_onehot - 16'h0001;
    cnt_next  = cnt_reg + 16'h0001;
    tick_next = 1'b0;
    if (div_onehot == 16'h0000) begin
      cnt_next  = 16'h0000;
      tick_next = 1'b1;
    end else if (cnt_reg >= last) begin
      // one high cycle per period: duty is no longer half, by design
      cnt_next  = 16'h0000;
      tick_next = 1'b1;
    end
  end

  // counter registers
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cnt_reg  <= 16'h0000;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign sclk_tick = tick_reg;

endmodule : scb_clkdiv

// *** src/scb_sysmgr.sv ***
// system configuration registers and external bus handover logic
//
// The Avalon-MM slave port was decided locally.
`timescale 1ns/1ps

module scb_sysmgr
  import scb_pkg::*;
#(
  parameter logic [4:0] PART_ID = 5'h0a  // arbitrary variant code
)
(
  input  wire logic              clk,
  input  wire logic              rstn,
  // avalon-mm slave
  input  wire logic [SCB_AW-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic [31:0]            avs_readdata,
  output logic                   avs_waitrequest,
  // outside bus master handshake pins
  input  wire logic              outside_master_request,
  output logic                   outside_master_grant,
  // memory controller side
  input  wire scb_mem_t          mem_from_ctrl,
  input  wire logic              mem_cycle_busy,
  input  wire logic              refresh_request,
  output logic                   refresh_go,
  // external memory pins, output half and enable
  output scb_mem_t               mem_pins_out,
  output logic                   mem_pins_oe,
  // clock source pin and derived controls
  input  wire logic              clock_source_select,
  output logic                   use_external_clock_input,
  output logic                   sclk_tick,
  output scb_cfg_t               cfg
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: first stage feeds only the second stage
  // reset clears both, so the request reads idle until released
  logic req_meta_reg;
  logic req_sync_reg;
  logic sel_meta_reg;
  logic sel_sync_reg;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      req_meta_reg <= 1'b0;
      req_sync_reg <= 1'b0;
      sel_meta_reg <= 1'b0;
      sel_sync_reg <= 1'b0;
    end else begin
      req_meta_reg <= outside_master_request;
      req_sync_reg <= req_meta_reg;
      sel_meta_reg <= clock_source_select;
      sel_sync_reg <= sel_meta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // handover state machine
  scb_state_t state_reg;
  scb_state_t state_next;
  logic       in_own;
  logic       in_drain;
  logic       in_granted;

  // wait for the running memory cycle to end before floating the bus,
  // so a synchronous DRAM write is never cut off half way
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      SCB_OWN: begin
        if (req_sync_reg) begin
          state_next = SCB_DRAIN;
        end
      end
      SCB_DRAIN: begin
        if (!req_sync_reg) begin
          state_next = SCB_OWN;
        end else if (!mem_cycle_busy) begin
          state_next = SCB_GRANTED;
        end
      end
      SCB_GRANTED: begin
        if (!req_sync_reg) begin
          state_next = SCB_RELEASE;
        end
      end
      SCB_RELEASE: begin
        state_next = SCB_OWN;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_reg <= SCB_OWN;
    end else begin
      state_reg <= state_next;
    end
  end

  // state decodes shared by the grant pin, refresh gate and status word
  assign in_own     = (state_reg == SCB_OWN);
  assign in_drain   = (state_reg == SCB_DRAIN);
  assign in_granted = (state_reg == SCB_GRANTED);

  // grant drops the same cycle the synced request does, so the outside
  // master sees grant only for the two sync cycles after it withdraws its request
  assign outside_master_grant = in_granted && req_sync_reg;

  // refresh only while this device owns the bus; the outside master
  // covers refresh itself during long ownership, and a refresh that
  // falls due while the bus is lent simply waits for the return
  assign refresh_go = refresh_request && in_own;

  ////////////////////////////////////////////////////////////////////////////
  // memory pin drivers, registered
  scb_mem_t mem_reg;
  scb_mem_t mem_next;
  logic     oe_reg;
  logic     oe_next;

  // enable falls as grant is entered and returns only after release;
  // pin data is a registered copy of the controller, one cycle late,
  // so data and enable both change on a clock edge, never in between
  always_comb begin
    mem_next = mem_from_ctrl;
    oe_next  = !((state_next == SCB_GRANTED) ||
                 (state_reg == SCB_GRANTED));
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      mem_reg <= '0;
      oe_reg  <= 1'b1;
    end else begin
      mem_reg <= mem_next;
      oe_reg  <= oe_next;
    end
  end

  assign mem_pins_out = mem_reg;
  assign mem_pins_oe  = oe_reg;

  ////////////////////////////////////////////////////////////////////////////
  // register file and bus slave
  logic [31:0] config_reg;
  logic [31:0] config_next;
  logic [31:0] clkdiv_reg;
  logic [31:0] clkdiv_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic        ack_reg;
  logic        ack_next;
  logic        hit;
  logic [15:0] ofs;
  logic [31:0] bemask;
  logic [31:0] config_view;
  logic [31:0] status_view;
  logic        sel_config;
  logic        sel_clkdiv;
  logic        sel_status;
  logic [31:0] rd_word;
  logic [31:0] config_merge;
  logic [31:0] clkdiv_merge;

  // window follows the live base field, so a base rewrite moves it at once
  assign hit = avs_address[SCB_AW-1:SCB_WIN_LSB] ==
               config_reg[SCB_CFG_SB_LSB +: SCB_WIN_W];
  assign ofs = avs_address[SCB_WIN_LSB-1:0];
  assign bemask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                   {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  // register selects; any other offset in the window reads zero and
  // swallows writes, so software probing unused offsets is harmless
  assign sel_config = hit && (ofs == SCB_OFS_CONFIG);
  assign sel_clkdiv = hit && (ofs == SCB_OFS_CLKDIV);
  assign sel_status = hit && (ofs == SCB_OFS_STATUS);

  // part identifier is fixed, never taken from the stored word
  always_comb begin
    config_view = config_reg;
    config_view[SCB_CFG_ID_LSB +: 5] = PART_ID;
    status_view = 32'h00000000;
    status_view[SCB_ST_GRANT] = outside_master_grant;
    status_view[SCB_ST_REQ]   = req_sync_reg;
    status_view[SCB_ST_DRAIN] = in_drain;
  end

  // read multiplexer, captured into the data register on the first cycle
  always_comb begin
    rd_word = 32'h00000000;
    if (sel_config) begin
      rd_word = config_view;
    end else if (sel_clkdiv) begin
      rd_word = clkdiv_reg;
    end else if (sel_status) begin
      rd_word = status_view;
    end
  end

  // byte lanes merged with the stored word; read-only bits never move
  assign config_merge = (config_reg & ~(bemask & SCB_CFG_WMASK)) |
                        (avs_writedata & bemask & SCB_CFG_WMASK);
  assign clkdiv_merge = (clkdiv_reg & ~(bemask & SCB_CLK_WMASK)) |
                        (avs_writedata & bemask & SCB_CLK_WMASK);

  // one wait cycle per access; the write lands when waitrequest is low
  always_comb begin
    ack_next    = (avs_read || avs_write) && !ack_reg;
    config_next = config_reg;
    clkdiv_next = clkdiv_reg;
    rdata_next  = rdata_reg;
    if (avs_read && !ack_reg) begin
      rdata_next = rd_word;
    end
    if (avs_write && ack_reg && sel_config) begin
      config_next = config_merge;
      // cache mode 10 leaves nothing to cache, so enable is cleared
      if (config_merge[SCB_CFG_CM_LSB +: 2] == SCB_CM_NOCACHE) begin
        config_next[SCB_CFG_CE] = 1'b0;
      end
    end
    if (avs_write && ack_reg && sel_clkdiv) begin
      clkdiv_next = clkdiv_merge;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      config_reg <= SCB_CFG_RESET & SCB_CFG_WMASK;
      clkdiv_reg <= SCB_CLK_RESET;
      rdata_reg  <= 32'h00000000;
      ack_reg    <= 1'b0;
    end else begin
      config_reg <= config_next;
      clkdiv_reg <= clkdiv_next;
      rdata_reg  <= rdata_next;
      ack_reg    <= ack_next;
    end
  end

  assign avs_readdata    = rdata_reg;
  assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;

  ////////////////////////////////////////////////////////////////////////////
  // decoded controls; cache re-enable never triggers a flush
  always_comb begin
    cfg.special_base        = config_reg[SCB_CFG_SB_LSB +: SCB_WIN_W];
    // sram base and cache mode together fix how the on-chip memory is
    // split between cache and plain sram
    cfg.sram_base           = config_reg[SCB_CFG_SR_LSB +: 10];
    cfg.cache_mode          = config_reg[SCB_CFG_CM_LSB +: 2];
    cfg.cache_enable        = config_reg[SCB_CFG_CE];
    cfg.write_buffer_enable = config_reg[SCB_CFG_WBE];
    // write-through keeps external memory coherent with the cache
    cfg.write_through       = 1'b1;
    cfg.stall_enable        = config_reg[SCB_CFG_STALL];
    cfg.sync_dram_mode      = config_reg[SCB_CFG_SDRAM];
    cfg.bank5_wait_enable   = clkdiv_reg[SCB_CLK_WAIT];
    cfg.bank5_mux_enable    = clkdiv_reg[SCB_CLK_MUX];
    // count of address-phase clocks minus one; 11 behaves as 10
    cfg.mux_address_phase_time =
      (clkdiv_reg[SCB_CLK_APH +: 2] == 2'h3) ? 2'h2 :
      clkdiv_reg[SCB_CLK_APH +: 2];
    cfg.factory_test        = clkdiv_reg[SCB_CLK_TEST];
  end

  // high pin selects the external clock, low the PLL; the switch itself
  // sits in the clock generator, which must keep it glitch free
  assign use_external_clock_input = sel_sync_reg;

  ////////////////////////////////////////////////////////////////////////////
  // clock divider
  scb_clkdiv u_clkdiv (
    .clk        (clk),
    .rstn       (rstn),
    .div_onehot (clkdiv_reg[15:0]),
    .sclk_tick  (sclk_tick)
  );

endmodule : scb_sysmgr

// *** testbench/scb_sysmgr_sva.sv ***
// checker: handover and configuration register timing
`timescale 1ns/1ps
module scb_sysmgr_sva
  import scb_pkg::*;
(
  input wire logic              clk,
  input wire logic              rstn,
  input wire logic [SCB_AW-1:0] avs_address,
  input wire logic              avs_read,
  input wire logic              avs_write,
  input wire logic [31:0]       avs_writedata,
  input wire logic [3:0]        avs_byteenable,
  input wire logic              avs_waitrequest,
  input wire logic              outside_master_request,
  input wire logic              outside_master_grant,
  input wire logic              refresh_go,
  input wire logic              mem_pins_oe,
  input wire scb_cfg_t          cfg
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  logic sys_wr;
  // accepted full-word write to the configuration word of this window
  assign sys_wr = avs_write && !avs_waitrequest && avs_byteenable == 4'hf
                  && avs_address[25:16] == cfg.special_base
                  && avs_address[15:0] == SCB_OFS_CONFIG;

  ////////////////////////////////////////////////////////////////////////
  // the pin passes two sync flops, so grant looks two samples back
  property p_grant_req;
    outside_master_grant |-> $past(outside_master_request, 2);
  endproperty
  a_grant_req: assert property (p_grant_req)
    else $error("grant without request");
  property p_float;
    outside_master_grant |-> !mem_pins_oe;
  endproperty
  a_float: assert property (p_float)
    else $error("pins driven during grant");
  property p_no_refresh;
    !mem_pins_oe |-> !refresh_go;
  endproperty
  a_no_refresh: assert property (p_no_refresh)
    else $error("refresh while bus lent");
  property p_hold;
    outside_master_grant && $past(outside_master_request) |=>
      outside_master_grant;
  endproperty
  a_hold: assert property (p_hold)
    else $error("grant dropped early");
  property p_release;
    $fell(outside_master_grant) |-> ##[1:3] mem_pins_oe;
  endproperty
  a_release: assert property (p_release)
    else $error("pins not driven again");
  property p_one_wait;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_one_wait: assert property (p_one_wait)
    else $error("bus answer late");
  property p_sdram;
    sys_wr |=> cfg.sync_dram_mode == $past(avs_writedata[31]);
  endproperty
  a_sdram: assert property (p_sdram)
    else $error("dram mode not taken");
  property p_ce_clear;
    sys_wr && avs_writedata[5:4] == SCB_CM_NOCACHE |=> !cfg.cache_enable;
  endproperty
  a_ce_clear: assert property (p_ce_clear)
    else $error("cache enable not cleared");
endmodule : scb_sysmgr_sva

bind scb_sysmgr scb_sysmgr_sva i_scb_sysmgr_sva (.clk, .rstn, .avs_address,
  .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_waitrequest,
  .outside_master_request, .outside_master_grant, .refresh_go,
  .mem_pins_oe, .cfg);

// *** testbench/scb_ext_master.sv ***
// far-side model: outside master that borrows the memory bus
`timescale 1ns/1ps
module scb_ext_master (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       start,
  input  wire logic [7:0] hold_len,
  input  wire logic       grant,
  output logic            request,
  output logic            drive_bus,
  output logic [7:0]      refreshes
);
  logic [7:0] cnt;
  // asks for the bus, keeps requesting for hold_len+1 granted cycles, then lets go
  always_ff @(posedge clk) begin
    if (!rstn) begin
      request   <= 1'b0;
      cnt       <= 8'h00;
      refreshes <= 8'h00;
    end else if (start) begin
      request <= 1'b1;
      cnt     <= 8'h00;
    end else if (request && grant) begin
      cnt <= cnt + 8'h01;
      if (cnt == hold_len) request <= 1'b0;
      // a long tenure must refresh dram itself
      if (cnt[3:0] == 4'hf) refreshes <= refreshes + 8'h01;
    end
  end
  // sdram select stays parked high; address only two clocks into grant
  assign drive_bus = grant && cnt >= 8'h02;
endmodule : scb_ext_master

// *** testbench/system_config_and_bus_handover_tb_top.sv ***
// testbench: register access and bus handover of the system manager
`timescale 1ns/1ps
module system_config_and_bus_handover_tb_top import scb_pkg::*;;
  localparam logic [4:0]  PID = 5'h0a; // arbitrary variant code
  localparam logic [25:0] B   = 26'h3ff0000;
  logic        clk, rstn, avs_read, avs_write, avs_waitrequest, sclk_tick;
  logic        outside_master_request, outside_master_grant, mem_pins_oe;
  logic        mem_cycle_busy, refresh_request, refresh_go, start, drive_bus;
  logic        clock_source_select, use_external_clock_input;
  logic [7:0]  hold_len, refreshes;
  logic [25:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [3:0]  avs_byteenable;
  logic [15:0] divs [4] = '{16'h0, 16'h1, 16'h4, 16'h10};
  scb_mem_t    mem_from_ctrl, mem_pins_out;
  scb_cfg_t    cfg;
  int          errors = 0, n_checks = 0, g;

  scb_sysmgr #(.PART_ID(PID)) i_scb_sysmgr (.clk, .rstn, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
    .avs_waitrequest, .outside_master_request, .outside_master_grant,
    .mem_from_ctrl, .mem_cycle_busy, .refresh_request, .refresh_go,
    .mem_pins_out, .mem_pins_oe, .clock_source_select,
    .use_external_clock_input, .sclk_tick, .cfg);
  scb_ext_master i_scb_ext_master (.clk, .rstn, .start, .hold_len,
    .grant(outside_master_grant), .request(outside_master_request),
    .drive_bus, .refreshes);

  always #10 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_checks++;
    if (s !== e) begin
      errors++;
      $display("MISMATCH %s exp %h got %h", nm, e, s);
    end
  endtask : chk
  // one avalon transfer; entered just after a rising edge
  task automatic bus(input logic w, input logic [25:0] a, input logic [31:0] d);
    int k;
    k = 0;
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= w;
    avs_read      <= !w;
    do begin
      @(posedge clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 50);
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    chk("bus_answer", 1, 32'(k < 50));
    @(posedge clk);
  endtask : bus
  task automatic rd(input string nm, input logic [25:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(nm, e, q);
  endtask : rd
  // bounded wait for the grant pin to reach a level
  task automatic wait_grant(input logic v);
    g = 0;
    while (outside_master_grant !== v && g < 40) begin
      @(negedge clk);
      g++;
    end
    chk("grant_level", 32'(v), 32'(outside_master_grant));
  endtask : wait_grant
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : test_done

  ////////////////////////////////////////////////////////////////////////
  // watchdog: the tests need some 500 cycles, a tenth of the 5000 allowed here
  initial begin
    #100us;
    chk("watchdog", 0, 1);
    test_done();
  end

  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = B;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    mem_cycle_busy = 1'b0;
    refresh_request = 1'b0;
    clock_source_select = 1'b0;
    start = 1'b0;
    hold_len = 8'h14;
    mem_from_ctrl = {22'h15a5a5, 32'hc3c3a5a5, 16'h5aa5};
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rd("config_rst", B, {1'b0, PID, 26'h3ffff91});
    rd("clkdiv_rst", B + 26'h3000, 32'h0);
    rd("unmapped", B + 26'h0004, 32'h0);
    rd("status_idle", B + 26'hfffc, 32'h0);
    $display("reset values done");
    bus(1'b1, B, 32'h83ff0026);
    chk("ce_cleared", 0, 32'(cfg.cache_enable));
    chk("sdram_mode", 1, 32'(cfg.sync_dram_mode));
    chk("wbuf_on", 1, 32'(cfg.write_buffer_enable));
    rd("config_rb", B, 32'h83ff0024 | {1'b0, PID, 26'h0});
    bus(1'b1, B, 32'h03ff0002);
    chk("ce_on", 1, 32'(cfg.cache_enable));
    bus(1'b1, B, 32'h03000000);
    rd("moved", 26'h3000000, {1'b0, PID, 26'h3000000});
    rd("old_gone", B, 32'h0);
    bus(1'b1, 26'h3000000, 32'h03ff0000);
    rd("back", B, {1'b0, PID, 26'h3ff0000});
    $display("configuration done");
    // every address-phase code, 11 acting as 10, bank 5 controls on
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, B + 26'h3000, {12'h0, i[1:0], 18'h30000});
      chk("addr_phase", i[1] ? 2 : i, 32'(cfg.mux_address_phase_time));
      chk("test_bit", 0, 32'(cfg.factory_test));
      chk("bank5_wait", 1, 32'(cfg.bank5_wait_enable));
      chk("bank5_mux", 1, 32'(cfg.bank5_mux_enable));
    end
    // tick count over 64 cycles after the old divider has died out
    foreach (divs[j]) begin
      bus(1'b1, B + 26'h3000, {16'h0, divs[j]});
      repeat (20) @(posedge clk);
      g = 0;
      repeat (64) begin
        @(negedge clk);
        if (sclk_tick === 1'b1) g++;
      end
      chk("ticks", 32'(64 / (divs[j] == 0 ? 1 : divs[j])), g);
      @(posedge clk);
    end
    chk("pll_clock", 0, 32'(use_external_clock_input));
    clock_source_select <= 1'b1;
    repeat (6) @(negedge clk);
    chk("ext_clock", 1, 32'(use_external_clock_input));
    $display("clock control done");
    // handover held off by a running memory cycle
    @(posedge clk);
    refresh_request <= 1'b1;
    mem_cycle_busy  <= 1'b1;
    start           <= 1'b1;
    @(negedge clk);
    chk("refresh_own", 1, 32'(refresh_go));
    @(posedge clk);
    start <= 1'b0;
    repeat (8) @(negedge clk);
    chk("busy_holds", 0, 32'(outside_master_grant));
    @(posedge clk);
    mem_cycle_busy <= 1'b0;
    wait_grant(1'b1);
    chk("float", 0, 32'(mem_pins_oe));
    chk("no_refresh", 0, 32'(refresh_go));
    repeat (3) @(negedge clk);
    chk("late_drive", 1, 32'(drive_bus && !mem_pins_oe));
    wait_grant(1'b0);
    repeat (3) @(negedge clk);
    chk("oe_back", 1, 32'(mem_pins_oe));
    chk("refresh_back", 1, 32'(refresh_go));
    chk("pins_back", 32'hc3c3a5a5, mem_pins_out.data);
    chk("ext_refresh", 1, 32'(refreshes));
    $display("handover done");
    test_done();
  end
endmodule : system_config_and_bus_handover_tb_top
